//--- rtl/bkm_break_monitor.sv
`timescale 1ns/1ps
`include "bkm_map.svh"

module bkm_break_monitor (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // CPU side
    input  wire logic [15:0] cpu_address,
    input  wire logic        cpu_address_is_pc,
    input  wire logic        cpu_in_break,
    input  wire logic        cpu_wait_exit,
    input  wire logic        cpu_low_power,
    input  wire logic [7:0]  reset_vector_high,
    input  wire logic [7:0]  reset_vector_low,
    // Entry pins
    input  wire logic        test_high_voltage,
    input  wire logic        irq_pin_level,
    input  wire logic        mode_select_a,
    input  wire logic        mode_select_b,
    // Serial pin
    input  wire logic        serial_comm_pin_in,
    output logic             serial_comm_pin_out,
    output logic             serial_comm_pin_oe,
    // To the rest of the chip
    output logic             break_request,
    output logic             watchdog_hold,
    output logic             flag_clear_allowed,
    output logic [15:0]      break_vector,
    output logic             monitor_mode,
    output logic             internal_osc_select,
    output logic             monitor_ready
);

    // Break registers
    logic       brk_enable, next_brk_enable;
    logic       brk_active, next_brk_active;
    logic [7:0] addr_high, next_addr_high;
    logic [7:0] addr_low, next_addr_low;
    logic       wdog_disable, next_wdog_disable;
    logic       wait_exit, next_wait_exit;
    logic       clear_enable, next_clear_enable;
    logic       match_q, next_match_q;
    logic       sw_break, next_sw_break;

    // Mode latch
    logic                 reset_q;
    bkm_pkg::bkm_mode_t   mode, next_mode;
    logic                 mode_valid, next_mode_valid;

    // Pin synchronisers
    logic [1:0] tst_sync, irq_sync, msa_sync, msb_sync, ser_sync;

    logic        wr_strobe;
    logic        rd_strobe;
    logic [7:0]  wbyte;
    logic        mapped;
    logic        pc_match;
    logic        vector_erased;
    logic        link_ready;
    logic [3:0]  bytes_seen;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    assign wr_strobe = psel && penable && pwrite;
    assign rd_strobe = psel && penable && !pwrite;
    assign wbyte     = pwdata[7:0];
    assign mapped    = addr_hit(paddr, `BKM_ADDR_STATUS_CONTROL)
                    || addr_hit(paddr, `BKM_ADDR_ADDRESS_HIGH)
                    || addr_hit(paddr, `BKM_ADDR_ADDRESS_LOW)
                    || addr_hit(paddr, `BKM_ADDR_AUXILIARY)
                    || addr_hit(paddr, `BKM_ADDR_WAIT_EXIT)
                    || addr_hit(paddr, `BKM_ADDR_FLAG_CONTROL)
                    || addr_hit(paddr, `BKM_ADDR_MONITOR_STATUS);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Full 16-bit compare on program counter addresses only; a halted bus never matches
    assign pc_match = brk_enable && cpu_address_is_pc && !cpu_low_power
                   && (cpu_address == {addr_high, addr_low});

    always_comb begin
        next_brk_enable   = brk_enable;
        next_brk_active   = brk_active;
        next_addr_high    = addr_high;
        next_addr_low     = addr_low;
        next_wdog_disable = wdog_disable;
        next_wait_exit    = wait_exit;
        next_clear_enable = clear_enable;
        next_match_q      = pc_match;
        next_sw_break     = 1'b0;
        if (wr_strobe) begin
            if (addr_hit(paddr, `BKM_ADDR_STATUS_CONTROL)) begin
                next_brk_enable = wbyte[`BKM_BIT_ENABLE];
                next_brk_active = wbyte[`BKM_BIT_ACTIVE];
                next_sw_break   = wbyte[`BKM_BIT_ACTIVE];
            end
            if (addr_hit(paddr, `BKM_ADDR_ADDRESS_HIGH)) begin
                next_addr_high = wbyte;
            end
            if (addr_hit(paddr, `BKM_ADDR_ADDRESS_LOW)) begin
                next_addr_low = wbyte;
            end
            if (addr_hit(paddr, `BKM_ADDR_AUXILIARY)) begin
                next_wdog_disable = wbyte[`BKM_BIT_WDOG_DISABLE];
            end
            if (addr_hit(paddr, `BKM_ADDR_WAIT_EXIT)) begin
                // Writing zero clears the flag; in break only if allowed
                if (!wbyte[`BKM_BIT_WAIT_EXIT] && (!cpu_in_break || clear_enable)) begin
                    next_wait_exit = 1'b0;
                end
            end
            if (addr_hit(paddr, `BKM_ADDR_FLAG_CONTROL)) begin
                next_clear_enable = wbyte[`BKM_BIT_CLEAR_ENABLE];
            end
        end
        // Hardware set wins over a clear in the same cycle
        if (match_q) begin
            next_brk_active = 1'b1;
        end
        if (cpu_wait_exit && cpu_in_break) begin
            next_wait_exit = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            brk_enable   <= 1'b0;
            brk_active   <= 1'b0;
            addr_high    <= `BKM_RESET_BYTE;
            addr_low     <= `BKM_RESET_BYTE;
            wdog_disable <= 1'b0;
            wait_exit    <= 1'b0;
            clear_enable <= 1'b0;
            match_q      <= 1'b0;
            sw_break     <= 1'b0;
        end else if (clk_en) begin
            brk_enable   <= next_brk_enable;
            brk_active   <= next_brk_active;
            addr_high    <= next_addr_high;
            addr_low     <= next_addr_low;
            wdog_disable <= next_wdog_disable;
            wait_exit    <= next_wait_exit;
            clear_enable <= next_clear_enable;
            match_q      <= next_match_q;
            sw_break     <= next_sw_break;
        end
    end

    // Two-stage synchronisers, left running through reset so pins settle before the latch
    always_ff @(posedge clk) begin
        if (clk_en) begin
            tst_sync <= {tst_sync[0], test_high_voltage};
            irq_sync <= {irq_sync[0], irq_pin_level};
            msa_sync <= {msa_sync[0], mode_select_a};
            msb_sync <= {msb_sync[0], mode_select_b};
            ser_sync <= {ser_sync[0], serial_comm_pin_in};
        end
    end

    assign vector_erased = (reset_vector_high == `BKM_ERASED_BYTE)
                        && (reset_vector_low == `BKM_ERASED_BYTE);

    // Entry decision, taken on the second enabled edge after reset release
    always_comb begin
        next_mode       = mode;
        next_mode_valid = mode_valid;
        if (!mode_valid && !reset_q) begin
            next_mode_valid = 1'b1;
            if (tst_sync[1] && msa_sync[1] && !msb_sync[1]) begin
                next_mode = bkm_pkg::BKM_MODE_NORMAL_MON;
            end else if (vector_erased) begin
                next_mode = irq_sync[1] ? bkm_pkg::BKM_MODE_FORCED_EXT
                                        : bkm_pkg::BKM_MODE_FORCED_INT;
            end else begin
                next_mode = bkm_pkg::BKM_MODE_USER;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reset_q    <= 1'b1;
            mode       <= bkm_pkg::BKM_MODE_USER;
            mode_valid <= 1'b0;
        end else if (clk_en) begin
            reset_q    <= 1'b0;
            mode       <= next_mode;
            mode_valid <= next_mode_valid;
        end
    end

    assign monitor_mode        = mode_valid && (mode != bkm_pkg::BKM_MODE_USER);
    assign internal_osc_select = mode_valid && (mode == bkm_pkg::BKM_MODE_FORCED_INT);

    bkm_monitor_link u_link (
        .clk              (clk),
        .clk_en           (clk_en),
        .reset            (reset),
        .link_enable      (monitor_mode),
        .use_internal_osc (internal_osc_select),
        .serial_in        (ser_sync[1]),
        .serial_out       (serial_comm_pin_out),
        .serial_oe        (serial_comm_pin_oe),
        .link_ready       (link_ready),
        .bytes_seen       (bytes_seen)
    );

    assign monitor_ready = link_ready;

    // Outputs to core
    assign break_request      = match_q || sw_break;
    assign watchdog_hold      = monitor_mode
                             || (wdog_disable && cpu_in_break);
    assign flag_clear_allowed = !cpu_in_break || clear_enable;
    assign break_vector       = monitor_mode ? 16'hfefc : 16'hfffc;

    // APB read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_strobe) begin
            if (addr_hit(paddr, `BKM_ADDR_STATUS_CONTROL)) begin
                prdata[`BKM_BIT_ENABLE] = brk_enable;
                prdata[`BKM_BIT_ACTIVE] = brk_active;
            end
            if (addr_hit(paddr, `BKM_ADDR_ADDRESS_HIGH)) begin
                prdata[7:0] = addr_high;
            end
            if (addr_hit(paddr, `BKM_ADDR_ADDRESS_LOW)) begin
                prdata[7:0] = addr_low;
            end
            if (addr_hit(paddr, `BKM_ADDR_AUXILIARY)) begin
                prdata[`BKM_BIT_WDOG_DISABLE] = wdog_disable;
            end
            if (addr_hit(paddr, `BKM_ADDR_WAIT_EXIT)) begin
                prdata[`BKM_BIT_WAIT_EXIT] = wait_exit;
            end
            if (addr_hit(paddr, `BKM_ADDR_FLAG_CONTROL)) begin
                prdata[`BKM_BIT_CLEAR_ENABLE] = clear_enable;
            end
            if (addr_hit(paddr, `BKM_ADDR_MONITOR_STATUS)) begin
                prdata[7:0] = {bytes_seen, link_ready, internal_osc_select, mode};
            end
        end
    end

endmodule : bkm_break_monitor

//--- inc/bkm_map.svh
`ifndef BKM_MAP_SVH
`define BKM_MAP_SVH

// Register byte addresses
`define BKM_ADDR_STATUS_CONTROL 12'h000
`define BKM_ADDR_ADDRESS_HIGH   12'h004
`define BKM_ADDR_ADDRESS_LOW    12'h008
`define BKM_ADDR_AUXILIARY      12'h00c
`define BKM_ADDR_WAIT_EXIT      12'h010
`define BKM_ADDR_FLAG_CONTROL   12'h014
`define BKM_ADDR_MONITOR_STATUS 12'h018

// Field positions
`define BKM_BIT_ENABLE          7
`define BKM_BIT_ACTIVE          6
`define BKM_BIT_WDOG_DISABLE    0
`define BKM_BIT_WAIT_EXIT       1
`define BKM_BIT_CLEAR_ENABLE    7

// Reset values
`define BKM_RESET_BYTE          8'h00
`define BKM_ERASED_BYTE         8'hff

// Monitor link
`define BKM_SECURITY_BYTES      4'h8
`define BKM_BREAK_BITS          4'ha
`define BKM_DIV_EXTERNAL        9'd256
`define BKM_DIV_INTERNAL        9'd335

`endif

//--- inc/bkm_pkg.sv
package bkm_pkg;

    typedef enum logic [1:0] {
        BKM_MODE_USER,
        BKM_MODE_NORMAL_MON,
        BKM_MODE_FORCED_EXT,
        BKM_MODE_FORCED_INT
    } bkm_mode_t;

    typedef enum logic [2:0] {
        BKM_LINK_IDLE,
        BKM_LINK_START,
        BKM_LINK_DATA,
        BKM_LINK_STOP,
        BKM_LINK_SEND,
        BKM_LINK_READY
    } bkm_link_state_t;

endpackage : bkm_pkg

//--- rtl/bkm_monitor_link.sv
`timescale 1ns/1ps
`include "bkm_map.svh"

// Counts security bytes from the host and answers with a break.
module bkm_monitor_link (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // Control
    input  wire logic       link_enable,
    input  wire logic       use_internal_osc,
    // Serial pin, already synchronised
    input  wire logic       serial_in,
    output logic            serial_out,
    output logic            serial_oe,
    // Status
    output logic            link_ready,
    output logic [3:0]      bytes_seen
);

    bkm_pkg::bkm_link_state_t state, next_state;
    logic [8:0] div_cnt, next_div_cnt;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [3:0] byte_cnt, next_byte_cnt;
    logic       pull_low, next_pull_low;
    logic [8:0] bit_len;
    logic       bit_tick;

    assign bit_len  = use_internal_osc ? `BKM_DIV_INTERNAL : `BKM_DIV_EXTERNAL;
    assign bit_tick = (div_cnt == bit_len - 9'd1);

    always_comb begin
        next_state    = state;
        next_div_cnt  = bit_tick ? 9'd0 : div_cnt + 9'd1;
        next_bit_cnt  = bit_cnt;
        next_byte_cnt = byte_cnt;
        next_pull_low = 1'b0;
        case (state)
            bkm_pkg::BKM_LINK_IDLE: begin
                next_div_cnt = 9'd0;
                if (link_enable && !serial_in) begin
                    next_state = bkm_pkg::BKM_LINK_START;
                end
            end
            bkm_pkg::BKM_LINK_START: begin
                // Half a bit in, confirm the start bit
                if (div_cnt == {1'b0, bit_len[8:1]}) begin
                    next_div_cnt = 9'd0;
                    next_bit_cnt = 4'd0;
                    next_state   = serial_in ? bkm_pkg::BKM_LINK_IDLE
                                             : bkm_pkg::BKM_LINK_DATA;
                end
            end
            bkm_pkg::BKM_LINK_DATA: begin
                if (bit_tick) begin
                    next_bit_cnt = bit_cnt + 4'd1;
                    if (bit_cnt == 4'd7) begin
                        next_state = bkm_pkg::BKM_LINK_STOP;
                    end
                end
            end
            bkm_pkg::BKM_LINK_STOP: begin
                if (bit_tick) begin
                    next_byte_cnt = byte_cnt + 4'd1;
                    if (byte_cnt == `BKM_SECURITY_BYTES - 4'd1) begin
                        next_state    = bkm_pkg::BKM_LINK_SEND;
                        next_bit_cnt  = 4'd0;
                        next_pull_low = 1'b1;
                    end else begin
                        next_state = bkm_pkg::BKM_LINK_IDLE;
                    end
                end
            end
            bkm_pkg::BKM_LINK_SEND: begin
                next_pull_low = 1'b1;
                if (bit_tick) begin
                    next_bit_cnt = bit_cnt + 4'd1;
                    if (bit_cnt == `BKM_BREAK_BITS - 4'd1) begin
                        next_state    = bkm_pkg::BKM_LINK_READY;
                        next_pull_low = 1'b0;
                    end
                end
            end
            bkm_pkg::BKM_LINK_READY: begin
                next_div_cnt = 9'd0;
            end
            default: begin
                next_state = bkm_pkg::BKM_LINK_IDLE;
            end
        endcase
        if (!link_enable) begin
            next_state    = bkm_pkg::BKM_LINK_IDLE;
            next_byte_cnt = 4'd0;
            next_pull_low = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= bkm_pkg::BKM_LINK_IDLE;
            div_cnt  <= 9'd0;
            bit_cnt  <= 4'd0;
            byte_cnt <= 4'd0;
            pull_low <= 1'b0;
        end else if (clk_en) begin
            state    <= next_state;
            div_cnt  <= next_div_cnt;
            bit_cnt  <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            pull_low <= next_pull_low;
        end
    end

    // Wired-OR: only ever drive low
    assign serial_out = 1'b0;
    assign serial_oe  = pull_low;
    assign link_ready = (state == bkm_pkg::BKM_LINK_READY);
    assign bytes_seen = byte_cnt;

endmodule : bkm_monitor_link

//--- sim/bkm_break_monitor_checker.sv
`timescale 1ns/1ps
`include "bkm_map.svh"

module bkm_break_monitor_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // CPU side
    input wire logic [15:0] cpu_address,
    input wire logic        cpu_address_is_pc,
    input wire logic        cpu_in_break,
    input wire logic        cpu_low_power,
    // Serial pin
    input wire logic        serial_comm_pin_out,
    input wire logic        serial_comm_pin_oe,
    // Chip outputs
    input wire logic        break_request,
    input wire logic        watchdog_hold,
    input wire logic [15:0] break_vector,
    input wire logic        monitor_mode,
    input wire logic        internal_osc_select,
    input wire logic        monitor_ready
);
    logic        en, aux, next_en, next_aux, wr_c, hit_c, cause_c;
    logic [15:0] addr_q, next_addr, oe_cnt, next_oe_cnt;
    logic [2:0]  age, next_age;

    // Shadow of the enable, watchdog-disable and address registers
    always_comb begin
        wr_c = psel && penable && pwrite && pready;
        hit_c = en && cpu_address == addr_q && cpu_address_is_pc && !cpu_low_power;
        cause_c = hit_c || (wr_c && paddr == `BKM_ADDR_STATUS_CONTROL && pwdata[6]);
        next_en = (wr_c && paddr == `BKM_ADDR_STATUS_CONTROL) ? pwdata[7] : en;
        next_aux = (wr_c && paddr == `BKM_ADDR_AUXILIARY) ? pwdata[0] : aux;
        next_addr = addr_q;
        if (wr_c && paddr == `BKM_ADDR_ADDRESS_HIGH) next_addr[15:8] = pwdata[7:0];
        if (wr_c && paddr == `BKM_ADDR_ADDRESS_LOW) next_addr[7:0] = pwdata[7:0];
        next_age = (age == 3'h7) ? age : age + 3'h1;
        next_oe_cnt = serial_comm_pin_oe ? oe_cnt + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            {en, aux, addr_q, age, oe_cnt} <= '0;
        end else begin
            {en, aux, addr_q, age, oe_cnt} <= {next_en, next_aux, next_addr, next_age, next_oe_cnt};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_hit; hit_c; endsequence
    sequence s_sw_write; wr_c && paddr == `BKM_ADDR_STATUS_CONTROL && pwdata[6]; endsequence
    sequence s_break_end; $fell(serial_comm_pin_oe); endsequence

    property p_match_break; s_hit |=> break_request; endproperty
    a_match_break: assert property (p_match_break) else $error("no break after match");
    property p_sw_break; s_sw_write |=> break_request; endproperty
    a_sw_break: assert property (p_sw_break) else $error("no break after write");
    property p_no_false; break_request |-> $past(cause_c); endproperty
    a_no_false: assert property (p_no_false) else $error("break without cause");
    property p_wdog_break; cpu_in_break && aux |-> watchdog_hold; endproperty
    a_wdog_break: assert property (p_wdog_break) else $error("watchdog runs in break");
    property p_wdog_mon; monitor_mode |-> watchdog_hold; endproperty
    a_wdog_mon: assert property (p_wdog_mon) else $error("watchdog runs in monitor");
    property p_vector; break_vector == (monitor_mode ? 16'hfefc : 16'hfffc); endproperty
    a_vector: assert property (p_vector) else $error("wrong break vector");
    property p_pull_low; serial_comm_pin_oe |-> !serial_comm_pin_out; endproperty
    a_pull_low: assert property (p_pull_low) else $error("pin driven high");
    property p_mode_hold; age == 3'h7 |-> $stable(monitor_mode) && $stable(internal_osc_select);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed after latch");
    property p_break_len;
        s_break_end |-> oe_cnt == (internal_osc_select ? 16'h0d16 : 16'h0a00);
    endproperty
    a_break_len: assert property (p_break_len) else $error("break length wrong");
    property p_ready; s_break_end |-> ##[0:2] monitor_ready; endproperty
    a_ready: assert property (p_ready) else $error("not ready after break");
endmodule : bkm_break_monitor_checker

bind bkm_break_monitor bkm_break_monitor_checker bkm_break_monitor_checker_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .cpu_address(cpu_address),
    .cpu_address_is_pc(cpu_address_is_pc), .cpu_in_break(cpu_in_break),
    .cpu_low_power(cpu_low_power), .serial_comm_pin_out(serial_comm_pin_out),
    .serial_comm_pin_oe(serial_comm_pin_oe), .break_request(break_request),
    .watchdog_hold(watchdog_hold), .break_vector(break_vector), .monitor_mode(monitor_mode),
    .internal_osc_select(internal_osc_select), .monitor_ready(monitor_ready)
);

//--- sim/bkm_host_model.sv
`timescale 1ns/1ps

// Host end of the monitor link: sends security bytes, then times the break
module bkm_host_model #(
    parameter int BIT_CLOCKS = 256
) (
    // Clock
    input  wire logic   clk,
    // Session
    input  wire logic   start,
    // Shared pin
    input  wire logic   pin,
    output logic        pull_low,
    // Result
    output logic [15:0] low_count,
    output logic        done
);
    logic [9:0] frame;
    int         n;

    initial begin
        pull_low = 1'b0;
        done = 1'b0;
        wait (start === 1'b1);
        for (int b = 0; b < 8; b++) begin
            frame = {1'b1, 8'h5a ^ 8'(b), 1'b0};
            for (int k = 0; k < 10; k++) begin
                @(posedge clk);
                pull_low <= !frame[k];
                repeat (BIT_CLOCKS - 1) @(posedge clk);
            end
        end
        n = 0;
        while (pin !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        while (pin === 1'b0) begin
            @(posedge clk);
        end
        done <= 1'b1;
    end

    // Counts only cycles in which the device holds the pin low
    always @(posedge clk) begin
        if (!start) begin
            low_count <= 16'h0000;
        end else if (pin === 1'b0 && pull_low === 1'b0) begin
            low_count <= low_count + 16'h0001;
        end
    end
endmodule : bkm_host_model

//--- sim/bkm_break_monitor_tb.sv
`timescale 1ns/1ps
`include "bkm_map.svh"

module bkm_break_monitor_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] addr = 16'h0000;
    logic        is_pc = 1'b0;
    logic        in_brk = 1'b0;
    logic        wexit = 1'b0;
    logic        lowp = 1'b0;
    logic [15:0] vec = 16'hffff;
    logic        hv = 1'b0;
    logic        irq = 1'b1;
    logic [1:0]  ms = 2'h0;
    logic        start = 1'b0;
    logic        pready, pslverr, brk, wdog, fclr, mmode, iosc, mready, oe, sout, hlow, hdone;
    logic [31:0] prdata;
    logic [15:0] bvec, lcount;
    wire         pin;
    logic [32:0] exp_q[$];
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          breaks = 0;
    int          seed = 42;

    always #2.5 clk = ~clk;
    // Wired-OR pin with pull-up
    assign pin = !((oe && !sout) || hlow);

    bkm_break_monitor bkm_break_monitor_inst (
        .clk(clk), .reset(reset), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_address(addr), .cpu_address_is_pc(is_pc),
        .cpu_in_break(in_brk), .cpu_wait_exit(wexit), .cpu_low_power(lowp),
        .reset_vector_high(vec[15:8]), .reset_vector_low(vec[7:0]), .test_high_voltage(hv),
        .irq_pin_level(irq), .mode_select_a(ms[1]), .mode_select_b(ms[0]),
        .serial_comm_pin_in(pin), .serial_comm_pin_out(sout), .serial_comm_pin_oe(oe),
        .break_request(brk), .watchdog_hold(wdog), .flag_clear_allowed(fclr),
        .break_vector(bvec), .monitor_mode(mmode), .internal_osc_select(iosc),
        .monitor_ready(mready)
    );

    bkm_host_model #(.BIT_CLOCKS(256)) bkm_host_model_inst (
        .clk(clk), .start(start), .pin(pin), .pull_low(hlow), .low_count(lcount), .done(hdone)
    );

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 8'h00);
    endtask : rd

    task automatic present(input logic [15:0] a, input logic pc, input logic lp);
        @(posedge clk);
        {addr, is_pc, lowp} <= {a, pc, lp};
        @(posedge clk);
        {addr, is_pc, lowp} <= {~a, 2'h0};
        repeat (2) @(posedge clk);
    endtask : present

    task automatic boot(input logic [15:0] v, input logic h, input logic q, input logic [1:0] m);
        @(posedge clk);
        {reset, vec, hv, irq, ms} <= {1'b1, v, h, q, m};
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : boot

    task automatic user_tests;
        logic [15:0] ba;
        ba = $random(seed);
        for (int k = 0; k < 6; k++) rd(12'(4 * k), 33'h0);
        rd(12'h01c, 33'h100000000);
        apb(1'b1, `BKM_ADDR_ADDRESS_HIGH, ba[15:8]);
        apb(1'b1, `BKM_ADDR_ADDRESS_LOW, ba[7:0]);
        rd(`BKM_ADDR_ADDRESS_HIGH, {25'h0, ba[15:8]});
        rd(`BKM_ADDR_ADDRESS_LOW, {25'h0, ba[7:0]});
        present(ba, 1'b1, 1'b0);
        apb(1'b1, `BKM_ADDR_STATUS_CONTROL, 8'h80);
        for (int b = 0; b < 16; b++) present(ba ^ (16'h0001 << b), 1'b1, 1'b0);
        present(ba, 1'b0, 1'b0);
        present(ba, 1'b1, 1'b1);
        rd(`BKM_ADDR_STATUS_CONTROL, 33'h080);
        check("breaks", breaks, 0);
        present(ba, 1'b1, 1'b0);
        rd(`BKM_ADDR_STATUS_CONTROL, 33'h0c0);
        apb(1'b1, `BKM_ADDR_STATUS_CONTROL, 8'h80);
        rd(`BKM_ADDR_STATUS_CONTROL, 33'h080);
        apb(1'b1, `BKM_ADDR_STATUS_CONTROL, 8'h40);
        rd(`BKM_ADDR_STATUS_CONTROL, 33'h040);
        check("breaks", breaks, 2);
        apb(1'b1, `BKM_ADDR_AUXILIARY, 8'h01);
        in_brk <= 1'b1;
        @(posedge clk);
        check("watchdog_hold", wdog, 1'b1);
        wexit <= 1'b1;
        @(posedge clk);
        wexit <= 1'b0;
        rd(`BKM_ADDR_WAIT_EXIT, 33'h002);
        apb(1'b1, `BKM_ADDR_WAIT_EXIT, 8'h00);
        rd(`BKM_ADDR_WAIT_EXIT, 33'h002);
        check("flag_clear", fclr, 1'b0);
        apb(1'b1, `BKM_ADDR_FLAG_CONTROL, 8'h80);
        @(posedge clk);
        check("flag_clear", fclr, 1'b1);
        apb(1'b1, `BKM_ADDR_WAIT_EXIT, 8'h00);
        rd(`BKM_ADDR_WAIT_EXIT, 33'h000);
        in_brk <= 1'b0;
        @(posedge clk);
        check("watchdog_hold", wdog, 1'b0);
    endtask : user_tests

    // Read results are judged as they appear; break pulses are counted for later checks
    always @(posedge clk) begin
        cycles++;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check("prdata", {pslverr, prdata}, exp_q.pop_front());
        end
        if (brk === 1'b1) begin
            breaks++;
        end
        if (cycles == 40000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] r;
        logic [1:0]  mode;
        int          n;
        // Entry table: user, normal monitor, forced internal, forced external
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            mode = (i == 2) ? 2'h3 : (i == 3) ? 2'h2 : 2'(i);
            boot((i < 2) ? {1'b0, r[14:0]} : 16'hffff, i == 1, i != 2, (i == 1) ? 2'h2 : r[1:0]);
            rd(`BKM_ADDR_MONITOR_STATUS, {30'h0, mode == 2'h3, mode});
            check("monitor_mode", mmode, mode != 2'h0);
            check("internal_osc", iosc, mode == 2'h3);
            check("watchdog_hold", wdog, mode != 2'h0);
            check("break_vector", bvec, (mode != 2'h0) ? 16'hfefc : 16'hfffc);
            if (i == 0) user_tests();
        end
        ms <= 2'h1;
        repeat (4) @(posedge clk);
        rd(`BKM_ADDR_MONITOR_STATUS, 33'h002);
        start <= 1'b1;
        n = 0;
        while (hdone !== 1'b1 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        check("break_low", lcount, 16'h0a00);
        check("monitor_ready", mready, 1'b1);
        rd(`BKM_ADDR_MONITOR_STATUS, 33'h08a);
        finish_test();
    end
endmodule : bkm_break_monitor_tb
